// >>> src/dll_pkg.sv
/*
  dll_pkg: register offsets, field positions, reset values and timing
  constants for the converter load, limit interrupt and reference control.
  Assumes a 32-bit APB register bus and a 125 MHz system clock.
*/
package dll_pkg;
  localparam int CLK_MHZ = 125;
  localparam int NUM_CH = 4;
  localparam int CODE_W = 12;
  // register byte offsets
  localparam logic [7:0] OFF_INPUT_BASE = 8'h00;
  localparam logic [7:0] OFF_DAC_BASE = 8'h10;
  localparam logic [7:0] OFF_CONFIG = 8'h20;
  localparam logic [7:0] OFF_LOAD_CMD = 8'h24;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h2C;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h30;
  localparam logic [7:0] OFF_LIMITS = 8'h34;
  localparam logic [7:0] OFF_PIN_STATE = 8'h38;
  // config fields
  localparam int CFG_LOAD_PIN_EN = 0;
  localparam int CFG_IRQ_ACT_HIGH = 1;
  localparam int CFG_REF_AB_BUF = 2;
  localparam int CFG_REF_CD_BUF = 3;
  localparam int CFG_REF_AB_INT = 4;
  localparam int CFG_REF_CD_INT = 5;
  localparam int CFG_W = 6;
  localparam logic [CFG_W-1:0] CFG_RESET = 6'h01;
  // interrupt status fields
  localparam int IRQ_TEMP = 0;
  localparam int IRQ_SUPPLY = 1;
  localparam int IRQ_LOAD = 2;
  localparam int IRQ_W = 3;
  // pin state fields
  localparam int PIN_FRAME = 0;
  localparam int PIN_LOAD = 1;
  localparam int PIN_LINK_CLK = 2;
  // timing
  localparam int LOAD_MIN_NS = 20;
  localparam int LOAD_MIN_CYC = (LOAD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  typedef enum logic [1:0] {
    DLL_FR_IDLE = 2'b00,
    DLL_FR_ACTIVE = 2'b01
  } dll_frame_e;
endpackage

// >>> src/dll_frame_shift.sv
/*
  dll_frame_shift: serial input register framed by the active-low select.
  Pins arrive already synchronised; samples data on link clock rising
  edges and shifts output on falling edges while the frame is active.
*/
`timescale 1ns/1ns
module dll_frame_shift import dll_pkg::*; #(
  parameter int WORD_W = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // synchronised pins
  input wire logic frame_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  // parallel side and serial output
  input wire logic [WORD_W-1:0] tx_word_i,
  output logic [WORD_W-1:0] rx_word_o,
  output logic rx_valid_o,
  output logic dout_o,
  output logic frame_active_o
);
  dll_frame_e state, next_state;
  logic sclk_d, next_sclk_d;
  logic [WORD_W-1:0] rx_sh, next_rx_sh, tx_sh, next_tx_sh, rx_word, next_rx_word;
  logic [$clog2(WORD_W+1)-1:0] cnt, next_cnt;
  logic valid, next_valid, dout, next_dout;
  logic rise, fall;

  assign rise = sclk_i & ~sclk_d;
  assign fall = ~sclk_i & sclk_d;

  always_comb begin
    next_state = state;
    next_sclk_d = sclk_i;
    next_rx_sh = rx_sh;
    next_tx_sh = tx_sh;
    next_rx_word = rx_word;
    next_cnt = cnt;
    next_valid = 1'b0;
    next_dout = dout;
    case (state)
      DLL_FR_IDLE: begin
        if (!frame_n_i) begin
          next_state = DLL_FR_ACTIVE;
          next_cnt = '0;
          next_tx_sh = tx_word_i;
          next_dout = tx_word_i[WORD_W-1];
        end
      end
      DLL_FR_ACTIVE: begin
        if (frame_n_i) begin
          next_state = DLL_FR_IDLE;
          next_dout = 1'b1;
        end else begin
          if (rise) begin
            next_rx_sh = {rx_sh[WORD_W-2:0], din_i};
            if (cnt == WORD_W[$bits(cnt)-1:0] - 1'b1) begin
              next_rx_word = {rx_sh[WORD_W-2:0], din_i};
              next_valid = 1'b1;
              next_cnt = '0;
            end else begin
              next_cnt = cnt + 1'b1;
            end
          end
          if (fall) begin
            next_tx_sh = {tx_sh[WORD_W-2:0], 1'b0};
            next_dout = tx_sh[WORD_W-2];
          end
        end
      end
      default: next_state = DLL_FR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state <= DLL_FR_IDLE;
      // idle level of the link clock, so no false edge follows reset
      sclk_d <= 1'b1;
      rx_sh <= '0;
      tx_sh <= '0;
      rx_word <= '0;
      cnt <= '0;
      valid <= 1'b0;
      dout <= 1'b1;
    end else begin
      state <= next_state;
      sclk_d <= next_sclk_d;
      rx_sh <= next_rx_sh;
      tx_sh <= next_tx_sh;
      rx_word <= next_rx_word;
      cnt <= next_cnt;
      valid <= next_valid;
      dout <= next_dout;
    end
  end

  assign rx_word_o = rx_word;
  assign rx_valid_o = valid;
  assign dout_o = dout;
  assign frame_active_o = (state == DLL_FR_ACTIVE);
endmodule

// >>> src/dll_load_ctrl.sv
/*
  dll_load_ctrl: top of the converter load, limit interrupt and reference
  control. APB slave for registers; pins are asynchronous and synchronised.
  Assumes a 125 MHz sys_clk_i and a synchronous active-low reset.
*/
// Behaviour
// - select falling enables serial input; sample on rising, shift on falling edge
// - load falling edge copies every fresh input register into converter register
// - config bit chooses pin-governed loading; pin governs after reset
// - open-drain limit interrupt, polarity selectable, active low by default
// - reference pair buffering configurable; pairs default to their reference pins
`timescale 1ns/1ns
module dll_load_ctrl import dll_pkg::*; #(
  parameter int CH = NUM_CH,
  parameter int CW = CODE_W
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // serial port pins
  input wire logic frame_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  // load pin and limit events
  input wire logic dac_load_n_i,
  input wire logic temp_over_i,
  input wire logic supply_over_i,
  // interrupt pin (open drain) and interrupt level
  output logic int_o,
  output logic int_oe_o,
  output logic irq_o,
  // converter side
  output logic [CH*CW-1:0] dac_code_o,
  output logic reference_in_ab_buf_o,
  output logic reference_in_cd_buf_o,
  output logic reference_in_ab_sel_int_o,
  output logic reference_in_cd_sel_int_o
);
  // two-flop synchronisers; stage one feeds only stage two
  logic [5:0] sync1, sync2, next_sync1, next_sync2;
  logic load_d, next_load_d;
  always_comb begin
    next_sync1 = {supply_over_i, temp_over_i, dac_load_n_i, din_i, sclk_i, frame_n_i};
    next_sync2 = sync1;
    next_load_d = sync2[3];
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sync1 <= 6'h0B;
      sync2 <= 6'h0B;
      load_d <= 1'b1;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      load_d <= next_load_d;
    end
  end
  logic f_n, s_clk, s_din, l_n, t_ov, v_ov, load_fall;
  assign {v_ov, t_ov, l_n, s_din, s_clk, f_n} = sync2;
  // relies on the host: a 20 ns pulse covers at least two clock edges, enough here
  assign load_fall = load_d & ~l_n;

  // serial input register
  logic [15:0] rx_word;
  logic rx_valid, ser_dout, frame_act;
  dll_frame_shift #(.WORD_W(16)) u_shift (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .frame_n_i(f_n),
    .sclk_i(s_clk),
    .din_i(s_din),
    .tx_word_i(16'h0000),
    .rx_word_o(rx_word),
    .rx_valid_o(rx_valid),
    .dout_o(ser_dout),
    .frame_active_o(frame_act)
  );

  // registers
  logic [CW-1:0] in_reg [CH];
  logic [CW-1:0] next_in_reg [CH];
  logic [CW-1:0] dac_reg [CH];
  logic [CW-1:0] next_dac_reg [CH];
  logic [CH-1:0] fresh, next_fresh;
  logic [CFG_W-1:0] cfg, next_cfg;
  logic [IRQ_W-1:0] irq_st, next_irq_st, irq_en, next_irq_en;
  logic wr, rd_access, sw_load, load_evt;

  assign wr = psel_i & penable_i & pwrite_i;
  assign rd_access = psel_i & penable_i & ~pwrite_i;
  assign sw_load = wr && (paddr_i == OFF_LOAD_CMD);
  // pin event when pin enabled, software strobe otherwise
  assign load_evt = cfg[CFG_LOAD_PIN_EN] ? load_fall : sw_load;

  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_ch
      logic sw_wr, ser_wr;
      assign sw_wr = wr && (paddr_i == OFF_INPUT_BASE + 8'(4 * g));
      // serial word: channel in [15:14], code below
      assign ser_wr = rx_valid && (rx_word[15:14] == 2'(g));
      always_comb begin
        next_in_reg[g] = in_reg[g];
        next_fresh[g] = fresh[g];
        next_dac_reg[g] = dac_reg[g];
        if (load_evt && fresh[g]) begin
          next_dac_reg[g] = in_reg[g];
          next_fresh[g] = 1'b0;
        end
        // a write in the load cycle keeps the fresh mark so it is not lost
        if (sw_wr) begin
          next_in_reg[g] = pwdata_i[CW-1:0];
          next_fresh[g] = 1'b1;
        end else if (ser_wr) begin
          next_in_reg[g] = rx_word[CW-1:0];
          next_fresh[g] = 1'b1;
        end
      end
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          in_reg[g] <= '0;
          dac_reg[g] <= '0;
          fresh[g] <= 1'b0;
        end else begin
          in_reg[g] <= next_in_reg[g];
          dac_reg[g] <= next_dac_reg[g];
          fresh[g] <= next_fresh[g];
        end
      end
      assign dac_code_o[g*CW +: CW] = dac_reg[g];
    end
  endgenerate

  // config and interrupt state
  always_comb begin
    next_cfg = cfg;
    next_irq_en = irq_en;
    next_irq_st = irq_st;
    if (wr && paddr_i == OFF_CONFIG) next_cfg = pwdata_i[CFG_W-1:0];
    if (wr && paddr_i == OFF_IRQ_ENABLE) next_irq_en = pwdata_i[IRQ_W-1:0];
    if (wr && paddr_i == OFF_IRQ_CLEAR) next_irq_st = irq_st & ~pwdata_i[IRQ_W-1:0];
    // set wins over a clear in the same cycle
    if (t_ov) next_irq_st[IRQ_TEMP] = 1'b1;
    if (v_ov) next_irq_st[IRQ_SUPPLY] = 1'b1;
    if (load_evt) next_irq_st[IRQ_LOAD] = 1'b1;
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg <= CFG_RESET;
      irq_st <= '0;
      irq_en <= '0;
    end else begin
      cfg <= next_cfg;
      irq_st <= next_irq_st;
      irq_en <= next_irq_en;
    end
  end

  // limit pin asserted while either limit status is pending and enabled
  logic limit_act, irq_lvl;
  assign limit_act = |(irq_st[IRQ_SUPPLY:IRQ_TEMP] & irq_en[IRQ_SUPPLY:IRQ_TEMP]);
  assign irq_lvl = |(irq_st & irq_en);
  // open drain can only pull low: active high relies on the pull-up when released
  assign int_o = 1'b0;
  assign int_oe_o = cfg[CFG_IRQ_ACT_HIGH] ? ~limit_act : limit_act;
  assign irq_o = irq_lvl;

  assign reference_in_ab_buf_o = cfg[CFG_REF_AB_BUF];
  assign reference_in_cd_buf_o = cfg[CFG_REF_CD_BUF];
  assign reference_in_ab_sel_int_o = cfg[CFG_REF_AB_INT];
  assign reference_in_cd_sel_int_o = cfg[CFG_REF_CD_INT];

  // serial output is open drain too
  assign dout_o = 1'b0;
  assign dout_oe_o = frame_act & ~ser_dout;

  // apb read data, registered; zero-wait answer
  logic [31:0] rdata, next_rdata;
  always_comb begin
    next_rdata = rdata;
    if (psel_i && !penable_i && !pwrite_i) begin
      next_rdata = RD_UNMAPPED;
      case (paddr_i)
        OFF_INPUT_BASE: next_rdata = 32'(in_reg[0]);
        OFF_INPUT_BASE + 8'h04: next_rdata = 32'(in_reg[1]);
        OFF_INPUT_BASE + 8'h08: next_rdata = 32'(in_reg[2]);
        OFF_INPUT_BASE + 8'h0C: next_rdata = 32'(in_reg[3]);
        OFF_DAC_BASE: next_rdata = 32'(dac_reg[0]);
        OFF_DAC_BASE + 8'h04: next_rdata = 32'(dac_reg[1]);
        OFF_DAC_BASE + 8'h08: next_rdata = 32'(dac_reg[2]);
        OFF_DAC_BASE + 8'h0C: next_rdata = 32'(dac_reg[3]);
        OFF_CONFIG: next_rdata = 32'(cfg);
        OFF_IRQ_STATUS: next_rdata = 32'(irq_st);
        OFF_IRQ_ENABLE: next_rdata = 32'(irq_en);
        OFF_LIMITS: next_rdata = 32'({v_ov, t_ov});
        OFF_PIN_STATE: next_rdata = 32'({s_clk, l_n, f_n});
        default: next_rdata = RD_UNMAPPED;
      endcase
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) rdata <= '0;
    else rdata <= next_rdata;
  end
  assign prdata_o = rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
endmodule

// >>> bench/dll_host_model.sv
/* dll_host_model: host on the select, link clock, data and load pins.
   Assumes the system clock as its time base; idle lines sit at pull-up. */
`timescale 1ns/1ns
module dll_host_model (
  // time base
  input wire logic sys_clk_i,
  // pins toward the device
  output logic frame_n_o,
  output logic sclk_o,
  output logic din_o,
  output logic dac_load_n_o
);
  initial begin
    frame_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o = 1'b1;
    dac_load_n_o = 1'b1;
  end
  // hp is the half period in system cycles, 5 gives the 80 ns link clock
  task automatic send_word(input logic [15:0] w, input int hp);
    frame_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (hp) @(posedge sys_clk_i);
      sclk_o <= 1'b0;
      din_o <= w[i];
      repeat (hp) @(posedge sys_clk_i);
      sclk_o <= 1'b1;
    end
    repeat (hp) @(posedge sys_clk_i);
    frame_n_o <= 1'b1;
    din_o <= 1'b1;
  endtask
  // 24 ns low: just over the minimum, so a slow detector shows up
  task automatic pulse_load();
    dac_load_n_o <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    dac_load_n_o <= 1'b1;
  endtask
endmodule

// >>> bench/dll_load_ctrl_checker.sv
/* dll_load_ctrl_checker: port assertions for dll_load_ctrl.
   Assumes one clock domain with a synchronous active-low reset. */
`timescale 1ns/1ns
module dll_load_ctrl_checker import dll_pkg::*; #(
  parameter int CH = NUM_CH,
  parameter int CW = CODE_W
) (
  // clock, reset and apb
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // pins
  input wire logic frame_n_i,
  input wire logic dac_load_n_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic int_o,
  input wire logic int_oe_o,
  input wire logic irq_o,
  // converter side
  input wire logic [CH*CW-1:0] dac_code_o,
  input wire logic reference_in_ab_sel_int_o,
  input wire logic reference_in_cd_sel_int_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic wr_acc, cfg_acc, ld_q, next_ld_q;
  logic [3:0] ld_age, next_ld_age, fr_hi, next_fr_hi;
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign cfg_acc = wr_acc && paddr_i == OFF_CONFIG;
  // ages saturate so a quiet spell never wraps back into the window
  always_comb begin
    next_ld_q = dac_load_n_i;
    next_ld_age = (ld_age == 4'hF) ? ld_age : ld_age + 4'h1;
    next_fr_hi = (fr_hi == 4'hF) ? fr_hi : fr_hi + 4'h1;
    if ((ld_q && !dac_load_n_i) || (wr_acc && paddr_i == OFF_LOAD_CMD)) begin
      next_ld_age = 4'h0;
    end
    if (!frame_n_i) begin
      next_fr_hi = 4'h0;
    end
    if (!rst_n_i) begin
      next_ld_q = 1'b1;
      next_ld_age = 4'hF;
      next_fr_hi = 4'hF;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    ld_q <= next_ld_q;
    ld_age <= next_ld_age;
    fr_hi <= next_fr_hi;
  end
  property p_apb_resp; pready_o && !pslverr_o; endproperty
  a_apb_resp: assert property (p_apb_resp) else $error("apb answer bad");
  property p_dout_low; dout_o == 1'b0; endproperty
  a_dout_low: assert property (p_dout_low) else $error("dout driven high");
  property p_dout_frame; dout_oe_o |-> fr_hi < 4'h6; endproperty
  a_dout_frame: assert property (p_dout_frame) else $error("dout outside frame");
  property p_int_low; int_o == 1'b0; endproperty
  a_int_low: assert property (p_int_low) else $error("int driven high");
  property p_rst_irq; $rose(rst_n_i) |-> !int_oe_o && !irq_o && dac_code_o == '0; endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("outputs not reset");
  property p_rst_ref; $rose(rst_n_i) |-> !reference_in_ab_sel_int_o && !reference_in_cd_sel_int_o;
  endproperty
  a_rst_ref: assert property (p_rst_ref) else $error("reference not external");
  property p_ref_wr;
    $changed({reference_in_ab_sel_int_o, reference_in_cd_sel_int_o}) |-> $past(cfg_acc);
  endproperty
  a_ref_wr: assert property (p_ref_wr) else $error("reference moved alone");
  property p_dac_hold; $changed(dac_code_o) |-> ld_age < 4'h9; endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("code moved without load");
endmodule
bind dll_load_ctrl dll_load_ctrl_checker #(.CH(CH), .CW(CW)) i_chk (
  .sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o, .pslverr_o,
  .frame_n_i, .dac_load_n_i, .dout_o, .dout_oe_o, .int_o, .int_oe_o, .irq_o, .dac_code_o,
  .reference_in_ab_sel_int_o, .reference_in_cd_sel_int_o
);

// >>> bench/dll_load_ctrl_tb.sv
/* dll_load_ctrl_tb: apb tests of dll_load_ctrl with a host model on the pins.
   Assumes the apb slave answers whenever it likes; the timeout ends a hang. */
`timescale 1ns/1ns
module dll_load_ctrl_tb import dll_pkg::*; ;
  logic sys_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic frame_n_i, sclk_i, din_i, dout_o, dout_oe_o, dac_load_n_i;
  logic temp_over_i, supply_over_i, int_o, int_oe_o, irq_o;
  logic [47:0] dac_code_o;
  logic [3:0] refs;
  int fail_count, cmp_count, cyc;
  dll_load_ctrl i_dut (
    .sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .frame_n_i, .sclk_i, .din_i, .dout_o, .dout_oe_o, .dac_load_n_i,
    .temp_over_i, .supply_over_i, .int_o, .int_oe_o, .irq_o, .dac_code_o,
    .reference_in_ab_buf_o(refs[3]), .reference_in_cd_buf_o(refs[2]),
    .reference_in_ab_sel_int_o(refs[1]), .reference_in_cd_sel_int_o(refs[0])
  );
  dll_host_model i_host (
    .sys_clk_i, .frame_n_o(frame_n_i), .sclk_o(sclk_i), .din_o(din_i),
    .dac_load_n_o(dac_load_n_i)
  );
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), {16'h0, e}, {16'h0, rd});
  endtask
  initial begin
    {rst_n_i, psel_i, penable_i, pwrite_i, temp_over_i, supply_over_i} = 6'h00;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    rdc(OFF_CONFIG, {26'h0, CFG_RESET});
    chk("refs", 48'h0, {44'h0, refs});
    i_host.send_word(16'h4ABC, 5);
    repeat (6) @(posedge sys_clk_i);
    rdc(OFF_INPUT_BASE + 8'h04, 32'hABC);
    apb(1'b1, OFF_INPUT_BASE + 8'h08, 32'h123);
    chk("held", 48'h0, dac_code_o);
    i_host.pulse_load();
    repeat (6) @(posedge sys_clk_i);
    chk("pin load", 48'h000123ABC000, dac_code_o);
    rdc(OFF_IRQ_STATUS, 32'h4);
    apb(1'b1, OFF_INPUT_BASE, 32'h5A5);
    i_host.send_word(16'hCFFF, 5);
    apb(1'b1, OFF_CONFIG, 32'h0);
    i_host.pulse_load();
    repeat (6) @(posedge sys_clk_i);
    chk("pin off", 48'h000123ABC000, dac_code_o);
    apb(1'b1, OFF_LOAD_CMD, 32'h1);
    chk("sw load", 48'hFFF123ABC5A5, dac_code_o);
    apb(1'b1, OFF_DAC_BASE, 32'h0);
    rdc(OFF_DAC_BASE, 32'h5A5);
    rdc(8'h3C, 32'h0);
    apb(1'b1, OFF_IRQ_CLEAR, 32'h7);
    apb(1'b1, OFF_IRQ_ENABLE, 32'h1);
    {temp_over_i, supply_over_i} <= 2'b11;
    repeat (5) @(posedge sys_clk_i);
    chk("irq set", 48'h3, {46'h0, int_oe_o, irq_o});
    {temp_over_i, supply_over_i} <= 2'b00;
    repeat (4) @(posedge sys_clk_i);
    rdc(OFF_IRQ_STATUS, 32'h3);
    apb(1'b1, OFF_IRQ_CLEAR, 32'h1);
    chk("masked", 48'h0, {46'h0, int_oe_o, irq_o});
    rdc(OFF_IRQ_STATUS, 32'h2);
    rdc(OFF_IRQ_CLEAR, 32'h0);
    apb(1'b1, OFF_CONFIG, 32'h2);
    chk("act high", 48'h2, {46'h0, int_oe_o, irq_o});
    {temp_over_i, supply_over_i} <= 2'b10;
    repeat (5) @(posedge sys_clk_i);
    chk("act high set", 48'h1, {46'h0, int_oe_o, irq_o});
    apb(1'b1, OFF_CONFIG, 32'h3C);
    chk("refs", 48'hF, {44'h0, refs});
    give_verdict();
  end
endmodule
